// >>> vsr_pkg.sv
// vendor status/interrupt register bank: shared constants and types
// assumes a 20 MHz core clock and a clause-22 style management frame
package vsr_pkg;

	// ****************************************
	// register indices and frame layout
	// ****************************************
	localparam logic [4:0] REG_SYM_ERR = 5'h1A;
	localparam logic [4:0] REG_XOVER = 5'h1B;
	localparam logic [4:0] REG_IRQ_FLAGS = 5'h1D;
	localparam logic [4:0] REG_IRQ_MASK = 5'h1E;
	localparam logic [4:0] REG_LINK_RESULT = 5'h1F;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [4:0] HDR_LAST = 5'h0C;
	localparam logic [4:0] DATA_LAST = 5'h0F;

	// ****************************************
	// field positions
	// ****************************************
	localparam int BIT_AUTO_XOVER_DIS = 15;
	localparam int BIT_PAIR_SWAP = 13;
	localparam int BIT_HEARTBEAT_OFF = 11;
	localparam int BIT_RX_POL = 4;
	localparam int BIT_AN_DONE = 12;
	localparam int BIT_BLOCK_CODE = 6;
	localparam int IRQ_LSB = 1;
	localparam int IRQ_MSB = 7;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [15:0] SYM_ERR_RESET = 16'h0000;
	localparam logic [6:0] IRQ_MASK_RESET = 7'h00;
	localparam logic BLOCK_CODE_RESET = 1'b1;
	localparam logic ENERGY_RESET = 1'b1;

	// ****************************************
	// timing
	// ****************************************
	localparam longint CLK_HZ = 20000000;
	localparam longint ENERGY_QUIET_MS = 256;
	localparam longint ENERGY_QUIET_CYCLES = ENERGY_QUIET_MS * CLK_HZ / 1000;

	// status levels and pulses from the receive and negotiation logic
	typedef struct packed {
		logic sym_invalid;
		logic rx_in_packet;
		logic speed_100;
		logic energy_seen;
		logic autoneg_done;
		logic remote_fault;
		logic link_up;
		logic partner_ack;
		logic parallel_fault;
		logic page_received;
		logic auto_pair_swap;
		logic rx_polarity_reversed;
		logic [2:0] resolved_speed_duplex;
	} vsr_status_t;

	typedef enum logic [1:0] {
		SMI_PREAMBLE,
		SMI_HEADER,
		SMI_TURN,
		SMI_DATA
	} vsr_smi_state_t;

endpackage

// >>> vsr_regs.sv
// vendor status, crossover and interrupt registers behind the serial
// management pins; assumes status inputs come from logic on CLK and
// that MDC is slower than a quarter of CLK
//
// Operation
// [R1] at 100 Mb/s count each invalid received code group, idle included
// [R2] count at most once per received packet
// [R3] count wraps to zero after its 16-bit maximum
// [R4] reset clears the count; reading does not clear it
// [R5] at 10 Mb/s the count stays unchanged
// [R6] bit 15 disables automatic crossover; bit 13 then picks pairs
// [R7] manual bit 13: 0 is straight pairs, 1 swaps them
// [R8] bit 11 turns the heartbeat test off; defaults to 0
// [R9] bit 4 reports reversed 10 Mb/s receive polarity; resets to 0
// [R10] flags 7,6,5 latch energy, negotiation done, remote fault
// [R11] flags 4,3,2,1 latch link down, ack, detect fault, page
// [R12] mask bits 7..1 enable matching flags; reset to 0
// [R13] bit 12 reads 1 once negotiation has finished
// [R14] bit 6 enables block coding, default 1; bypass needs MII mode; the code has no MII mode and takes a 0 write at any time
// [R15] bits 4:2 report resolved speed and duplex
// [R16] energy present falls after a quiet interval without line energy
// [R17] interrupt asserted while any enabled flag is set
`timescale 1ns/100ps
`default_nettype none

module vsr_regs
	import vsr_pkg::*;
#(
	parameter logic [4:0] PHY_ADDR = 5'h00,
	parameter int unsigned QUIET_CYCLES = 32'(ENERGY_QUIET_CYCLES)
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic MDC,
	input wire logic MDIO_I,
	output logic MDIO_O,
	output logic MDIO_OE,
	input wire vsr_status_t STATUS,
	output logic AUTO_XOVER_DISABLE,
	output logic PAIR_SWAP,
	output logic HEARTBEAT_TEST_OFF,
	output logic BLOCK_CODE_ENABLE,
	output logic IRQ_N
);

	// ****************************************
	// pin synchronisers and clock edge
	// ****************************************
	logic mdc_s1_q, mdc_s2_q, mdc_s3_q;
	logic mdio_s1_q, mdio_s2_q;
	wire mdc_rise = mdc_s2_q & ~mdc_s3_q;

	// two stages for each pin, third stage only for edge finding
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			{mdc_s1_q, mdc_s2_q, mdc_s3_q} <= 3'h0;
			{mdio_s1_q, mdio_s2_q} <= 2'h3;
		end else begin
			{mdc_s1_q, mdc_s2_q, mdc_s3_q} <= {MDC, mdc_s1_q, mdc_s2_q};
			{mdio_s1_q, mdio_s2_q} <= {MDIO_I, mdio_s1_q};
		end
	end

	// ****************************************
	// symbol error counter
	// ****************************************
	logic [15:0] sym_cnt_q;
	logic pkt_hit_q;
	// [R1] [R5] count qualifier
	wire sym_ev = STATUS.sym_invalid & STATUS.speed_100 &
		~(STATUS.rx_in_packet & pkt_hit_q);
	// [R2] once per packet
	wire pkt_hit_d = STATUS.rx_in_packet & (pkt_hit_q | sym_ev);

	// [R3] [R4] wrapping count, cleared only by reset
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sym_cnt_q <= SYM_ERR_RESET;
			pkt_hit_q <= 1'b0;
		end else begin
			sym_cnt_q <= sym_cnt_q + {15'h0000, sym_ev};
			pkt_hit_q <= pkt_hit_d;
		end
	end

	// ****************************************
	// energy detect timer
	// ****************************************
	logic energy_q;
	logic [31:0] quiet_cnt_q;
	wire quiet_done = (quiet_cnt_q >= QUIET_CYCLES - 32'h1);

	// [R16] drop energy after the quiet interval
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			energy_q <= ENERGY_RESET;
			quiet_cnt_q <= 32'h0;
		end else if (STATUS.energy_seen) begin
			energy_q <= 1'b1;
			quiet_cnt_q <= 32'h0;
		end else if (quiet_done) begin
			energy_q <= 1'b0;
		end else begin
			quiet_cnt_q <= quiet_cnt_q + 32'h1;
		end
	end

	// ****************************************
	// interrupt flags and mask
	// ****************************************
	logic [6:0] prev_q;
	logic [6:0] flags_q;
	logic [6:0] mask_q;
	logic flags_rd_clr;
	wire [6:0] level_now = {energy_q, STATUS.autoneg_done,
		STATUS.remote_fault, ~STATUS.link_up, STATUS.partner_ack,
		STATUS.parallel_fault, STATUS.page_received};
	// [R10] [R11] rising edge of each source
	wire [6:0] irq_ev = level_now & ~prev_q;
	// latched high until read; a new event wins over the read clear
	wire [6:0] flags_d = (flags_q & {7{~flags_rd_clr}}) | irq_ev;

	// flags hold once set until a read of the flag register clears them
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			// energy present and link down are the post-reset levels,
			// so neither may show a false edge on the first cycle
			prev_q <= 7'h48;
			flags_q <= 7'h00;
		end else begin
			prev_q <= level_now;
			flags_q <= flags_d;
		end
	end

	// [R17] gated interrupt, active low
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			IRQ_N <= 1'b1;
		else
			IRQ_N <= ~|(flags_q & mask_q);
	end

	// ****************************************
	// control registers
	// ****************************************
	logic [4:0] spare_q;
	logic rx_pol_q;
	logic wr_stb;
	logic [4:0] reg_sel_q;
	logic [15:0] shift_q;
	wire [15:0] wr_data = {shift_q[14:0], mdio_s2_q};
	wire wr_xover = wr_stb && reg_sel_q == REG_XOVER;
	wire wr_mask = wr_stb && reg_sel_q == REG_IRQ_MASK;
	wire wr_link = wr_stb && reg_sel_q == REG_LINK_RESULT;

	// [R6] [R8] [R12] [R14] writable bits
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			AUTO_XOVER_DISABLE <= 1'b0;
			HEARTBEAT_TEST_OFF <= 1'b0;
			mask_q <= IRQ_MASK_RESET;
			BLOCK_CODE_ENABLE <= BLOCK_CODE_RESET;
			spare_q <= 5'h00;
		end else begin
			if (wr_xover) begin
				AUTO_XOVER_DISABLE <= wr_data[BIT_AUTO_XOVER_DIS];
				HEARTBEAT_TEST_OFF <= wr_data[BIT_HEARTBEAT_OFF];
			end
			if (wr_mask)
				mask_q <= wr_data[IRQ_MSB:IRQ_LSB];
			if (wr_link) begin
				BLOCK_CODE_ENABLE <= wr_data[BIT_BLOCK_CODE];
				spare_q <= wr_data[11:7];
			end
		end
	end

	// [R7] manual pair choice, separate so it holds its own write
	logic manual_swap_q;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			manual_swap_q <= 1'b0;
			PAIR_SWAP <= 1'b0;
			rx_pol_q <= 1'b0;
		end else begin
			if (wr_xover)
				manual_swap_q <= wr_data[BIT_PAIR_SWAP];
			PAIR_SWAP <= AUTO_XOVER_DISABLE ? manual_swap_q :
				STATUS.auto_pair_swap;
			// [R9] polarity snapshot
			rx_pol_q <= STATUS.rx_polarity_reversed;
		end
	end

	// ****************************************
	// read data selection
	// ****************************************
	logic [4:0] ra;
	wire [15:0] rd_xover = {AUTO_XOVER_DISABLE, 1'b0, manual_swap_q, 1'b0,
		HEARTBEAT_TEST_OFF, 6'h00, rx_pol_q, 4'h0};
	// [R13] [R15] negotiation and resolved mode
	wire [15:0] rd_link = {3'h0, STATUS.autoneg_done, spare_q,
		BLOCK_CODE_ENABLE, 1'b0, STATUS.resolved_speed_duplex, 2'h0};
	wire [15:0] rd_word =
		(ra == REG_SYM_ERR) ? sym_cnt_q :
		(ra == REG_XOVER) ? rd_xover :
		(ra == REG_IRQ_FLAGS) ? {8'h00, flags_q, 1'b0} :
		(ra == REG_IRQ_MASK) ? {8'h00, mask_q, 1'b0} :
		(ra == REG_LINK_RESULT) ? rd_link : 16'h0000;

	// ****************************************
	// management frame engine
	// ****************************************
	vsr_smi_state_t state_q;
	logic [5:0] pre_cnt_q;
	logic [4:0] bit_cnt_q;
	logic [12:0] hdr_q;
	logic is_read_q;
	wire [12:0] hdr_full = {hdr_q[11:0], mdio_s2_q};
	assign ra = hdr_full[4:0];
	wire hdr_end = mdc_rise && state_q == SMI_HEADER && bit_cnt_q == HDR_LAST;
	wire hdr_ok = hdr_full[12] && hdr_full[9:5] == PHY_ADDR &&
		(hdr_full[11:10] == OP_READ || hdr_full[11:10] == OP_WRITE);
	wire rd_start = hdr_end && hdr_ok && hdr_full[11:10] == OP_READ;
	wire data_end = mdc_rise && state_q == SMI_DATA && bit_cnt_q == DATA_LAST;
	assign wr_stb = data_end && !is_read_q;
	// reading the flag register clears them as the word is captured
	assign flags_rd_clr = rd_start && ra == REG_IRQ_FLAGS;

	// frame sequencing on sampled clock rises
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= SMI_PREAMBLE;
			pre_cnt_q <= 6'h00;
			bit_cnt_q <= 5'h00;
			hdr_q <= 13'h0000;
			is_read_q <= 1'b0;
			reg_sel_q <= 5'h00;
		end else if (mdc_rise) begin
			bit_cnt_q <= bit_cnt_q + 5'h01;
			unique case (state_q)
				SMI_PREAMBLE: begin
					bit_cnt_q <= 5'h00;
					if (mdio_s2_q)
						pre_cnt_q <= (pre_cnt_q == PREAMBLE_LEN) ?
							pre_cnt_q : pre_cnt_q + 6'h01;
					else begin
						pre_cnt_q <= 6'h00;
						if (pre_cnt_q == PREAMBLE_LEN)
							state_q <= SMI_HEADER;
					end
				end
				SMI_HEADER: begin
					hdr_q <= hdr_full;
					if (bit_cnt_q == HDR_LAST) begin
						bit_cnt_q <= 5'h00;
						state_q <= hdr_ok ? SMI_TURN : SMI_PREAMBLE;
						is_read_q <= hdr_full[11:10] == OP_READ;
						reg_sel_q <= ra;
					end
				end
				SMI_TURN: begin
					if (bit_cnt_q[0]) begin
						bit_cnt_q <= 5'h00;
						state_q <= SMI_DATA;
					end
				end
				SMI_DATA: begin
					if (bit_cnt_q == DATA_LAST)
						state_q <= SMI_PREAMBLE;
				end
			endcase
		end
	end

	// data shifter and pin drive; turnaround drives zero on its second bit
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			shift_q <= 16'h0000;
			MDIO_O <= 1'b0;
			MDIO_OE <= 1'b0;
		end else if (rd_start) begin
			shift_q <= rd_word;
		end else if (mdc_rise && is_read_q) begin
			if (state_q == SMI_TURN && !bit_cnt_q[0]) begin
				MDIO_OE <= 1'b1;
				MDIO_O <= 1'b0;
			end else if (state_q == SMI_TURN || state_q == SMI_DATA) begin
				MDIO_O <= shift_q[15];
				shift_q <= {shift_q[14:0], 1'b0};
				if (data_end)
					MDIO_OE <= 1'b0;
			end
		end else if (mdc_rise && state_q == SMI_DATA) begin
			shift_q <= wr_data;
		end
	end

endmodule

`default_nettype wire

// >>> vsr_sva.sv
// pin checker for the vendor register bank
// assumes MDC rests low between management frames
`timescale 1ns/100ps
`default_nettype none
module vsr_sva
	import vsr_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic MDC,
	input wire logic MDIO_OE,
	input wire vsr_status_t STATUS,
	input wire logic AUTO_XOVER_DISABLE,
	input wire logic PAIR_SWAP,
	input wire logic HEARTBEAT_TEST_OFF,
	input wire logic BLOCK_CODE_ENABLE,
	input wire logic IRQ_N
);
	// ****
	// cycles since MDC was last high
	// ****
	logic [7:0] idle_q;
	logic near;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) idle_q <= 8'hFF;
		else if (MDC) idle_q <= 8'h00;
		else if (idle_q != 8'hFF) idle_q <= idle_q + 8'h01;
	end
	assign near = idle_q < 8'h10;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	rst_vals_a: assert property ($rose(RST_N) |-> IRQ_N &&
		BLOCK_CODE_ENABLE && !AUTO_XOVER_DISABLE && !HEARTBEAT_TEST_OFF)
		else $error("pins not at reset levels");
	pair_auto_a: assert property (!near && !AUTO_XOVER_DISABLE &&
		$past(RST_N) |-> PAIR_SWAP == $past(STATUS.auto_pair_swap))
		else $error("pair swap not following auto decision");
	pair_hold_a: assert property (AUTO_XOVER_DISABLE && !near
		|-> $stable(PAIR_SWAP)) else $error("manual pair swap moved");
	xover_quiet_a: assert property (!near
		|-> $stable(AUTO_XOVER_DISABLE)) else $error("crossover bit moved");
	hb_quiet_a: assert property (!near
		|-> $stable(HEARTBEAT_TEST_OFF)) else $error("heartbeat bit moved");
	code_quiet_a: assert property (!near
		|-> $stable(BLOCK_CODE_ENABLE)) else $error("coding bit moved");
	irq_clear_a: assert property ($rose(IRQ_N) |-> near)
		else $error("interrupt released without a frame");
	oe_start_a: assert property ($rose(MDIO_OE) |-> near)
		else $error("data driven outside a frame");
	cover property ($fell(IRQ_N));
	cover property ($rose(PAIR_SWAP) && AUTO_XOVER_DISABLE);
	cover property ($fell(MDIO_OE));
endmodule
bind vsr_regs vsr_sva u_sva (.CLK(CLK), .RST_N(RST_N), .MDC(MDC),
	.MDIO_OE(MDIO_OE), .STATUS(STATUS), .PAIR_SWAP(PAIR_SWAP),
	.AUTO_XOVER_DISABLE(AUTO_XOVER_DISABLE), .IRQ_N(IRQ_N),
	.HEARTBEAT_TEST_OFF(HEARTBEAT_TEST_OFF),
	.BLOCK_CODE_ENABLE(BLOCK_CODE_ENABLE));
`default_nettype wire

// >>> vsr_mgmt_host.sv
// management station model issuing serial frames
// assumes the data line is pulled high when released
`timescale 1ns/100ps
`default_nettype none
module vsr_mgmt_host
	import vsr_pkg::*;
(
	input wire logic CLK,
	output logic MDC,
	output logic HOST_OE,
	output logic HOST_D,
	input wire logic LINE
);
	// ****
	// one frame, MDC low for 7 CLK then high for 8 CLK
	// ****
	initial begin
		MDC = 1'h0;
		HOST_OE = 1'h0;
		HOST_D = 1'h1;
	end
	task automatic frame(input logic [1:0] op, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rdv);
		logic [63:0] f;
		f = {32'hFFFFFFFF, 2'h1, op, 5'h00, ra, 2'h2, wd};
		for (int i = 63; i >= 0; i--) begin
			@(posedge CLK);
			MDC <= 1'h0;
			HOST_OE <= (i > 17) || (op == OP_WRITE);
			HOST_D <= f[i];
			repeat (7) @(posedge CLK);
			MDC <= 1'h1;
			if (i < 16) rdv[i] = LINE;
			repeat (7) @(posedge CLK);
		end
		@(posedge CLK);
		MDC <= 1'h0;
		HOST_OE <= 1'h0;
	endtask
endmodule
`default_nettype wire

// >>> vsr_regs_tb.sv
// self-checking bench for the vendor register bank
// frames come from the host model, status lines from here
`timescale 1ns/100ps
`default_nettype none
module vsr_regs_tb import vsr_pkg::*;;
	logic CLK = 1'h0;
	logic RST_N = 1'h0;
	logic mdc, host_oe, host_d, mdio_o, mdio_oe, line;
	logic axd, pair, hb, bce, irq_n;
	vsr_status_t st = '0;
	logic [15:0] exp_q[$], got_q[$], rd;
	logic [2:0] sd [4] = '{3'h1, 3'h5, 3'h2, 3'h6};
	logic [15:0] xv [2] = '{16'hA800, 16'h8800};
	int bad_count = 0;
	int comparisons = 0;
	always #25 CLK = ~CLK;
	// pulled-up data line
	assign line = mdio_oe ? mdio_o : (host_oe ? host_d : 1'h1);
	vsr_regs #(.QUIET_CYCLES(50)) DUT (.CLK(CLK), .RST_N(RST_N),
		.MDC(mdc), .MDIO_I(line), .MDIO_O(mdio_o), .MDIO_OE(mdio_oe),
		.STATUS(st), .AUTO_XOVER_DISABLE(axd), .PAIR_SWAP(pair),
		.HEARTBEAT_TEST_OFF(hb), .BLOCK_CODE_ENABLE(bce), .IRQ_N(irq_n));
	vsr_mgmt_host host (.CLK(CLK), .MDC(mdc), .HOST_OE(host_oe),
		.HOST_D(host_d), .LINE(line));
	// ****
	// tasks
	// ****
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
	endtask
	task automatic note(input logic [15:0] e, input logic [15:0] g);
		exp_q.push_back(e);
		got_q.push_back(g);
	endtask
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rd_chk(input logic [4:0] ra, input logic [15:0] e);
		host.frame(OP_READ, ra, 16'h0000, rd);
		note(e, rd);
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] v);
		host.frame(OP_WRITE, ra, v, rd);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// oldest note against each result
	always begin
		wait (got_q.size() != 0);
		chk(exp_q.pop_front(), got_q.pop_front());
	end
	always @(posedge CLK) st.auto_pair_swap <= 1'($urandom);
	initial begin
		tick(98000);
		bad_count++;
		give_verdict;
	end
	// ****
	// tests
	// ****
	initial begin
		int n;
		void'($urandom(63708));
		st.rx_polarity_reversed <= 1'($urandom);
		tick(6);
		RST_N <= 1'h1;
		tick(2);
		note(16'h1, 16'(bce));
		rd_chk(REG_SYM_ERR, 16'h0);
		rd_chk(REG_XOVER, 16'(st.rx_polarity_reversed) << 4);
		rd_chk(5'h1C, 16'h0);
		rd_chk(REG_IRQ_MASK, 16'h0);
		rd_chk(REG_IRQ_FLAGS, 16'h0);
		$display("test reset done");
		wr(REG_LINK_RESULT, 16'h0F80);
		note(16'h0, 16'(bce));
		for (int i = 0; i < 4; i++) begin
			st.resolved_speed_duplex <= sd[i];
			st.autoneg_done <= 1'(i);
			rd_chk(REG_LINK_RESULT, 16'h0F80 | 16'(i % 2) << 12 | 16'(sd[i]) << 2);
		end
		wr(REG_LINK_RESULT, 16'h0040);
		note(16'h1, 16'(bce));
		$display("test link result done");
		for (int i = 0; i < 2; i++) begin
			wr(REG_XOVER, xv[i]);
			note(16'({xv[i][15], xv[i][13], xv[i][11]}), 16'({axd, pair, hb}));
		end
		rd_chk(REG_XOVER, 16'h8800 | 16'(st.rx_polarity_reversed) << 4);
		wr(REG_XOVER, 16'h0000);
		$display("test crossover done");
		n = $urandom_range(20, 1);
		st.speed_100 <= 1'h1;
		for (int i = 0; i < n + 8; i++) begin
			if (i == n) st.rx_in_packet <= 1'h1;
			if (i == n + 3) st.speed_100 <= 1'h0;
			st.sym_invalid <= 1'h1;
			tick(1);
			st.sym_invalid <= 1'h0;
			tick(1);
		end
		st.rx_in_packet <= 1'h0;
		rd_chk(REG_SYM_ERR, 16'(n + 1));
		st.speed_100 <= 1'h1;
		st.sym_invalid <= 1'h1;
		tick(65539 - n);
		st.sym_invalid <= 1'h0;
		rd_chk(REG_SYM_ERR, 16'h4);
		rd_chk(REG_SYM_ERR, 16'h4);
		$display("test count done");
		st.link_up <= 1'h1;
		st.autoneg_done <= 1'h0;
		rd_chk(REG_IRQ_FLAGS, 16'h0040);
		wr(REG_IRQ_MASK, 16'h0002);
		{st.energy_seen, st.autoneg_done, st.remote_fault} <= 3'h7;
		{st.link_up, st.partner_ack, st.parallel_fault} <= 3'h3;
		tick(1);
		st.energy_seen <= 1'h0;
		tick(4);
		note(16'h1, 16'(irq_n));
		rd_chk(REG_IRQ_FLAGS, 16'h00FC);
		st.page_received <= 1'h1;
		st.energy_seen <= 1'h1;
		tick(1);
		st.energy_seen <= 1'h0;
		tick(4);
		note(16'h0, 16'(irq_n));
		rd_chk(REG_IRQ_MASK, 16'h0002);
		rd_chk(REG_IRQ_FLAGS, 16'h0082);
		tick(2);
		note(16'h1, 16'(irq_n));
		$display("test interrupt done");
		tick(10);
		give_verdict;
	end
endmodule
`default_nettype wire
